// ===== rtl/hdp_pkg.sv
// hdp_pkg: constants and carrier types for the hub downstream port manager.
// assumes a 10 MHz device clock and a 32-bit APB register bus.
package hdp_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned NPORT = 7;
  localparam int unsigned CNT_W = 5;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_CONNECT = 8'h00;
  localparam logic [7:0] OFF_SPEED = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_FORCE = 8'h0c;
  localparam logic [7:0] OFF_SUSPEND = 8'h10;
  localparam logic [7:0] OFF_HUBCTL = 8'h14;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned HUBCTL_IRQ_EN = 0;
  localparam int unsigned HUBCTL_SUSP = 1;
  localparam logic [6:0] PORTS_RST = 7'h00;
  localparam logic [13:0] FORCE_RST = 14'h0000;
  localparam logic [1:0] HUBCTL_RST = 2'h0;

  // ==========================================================
  // per-port forcing codes
  localparam logic [1:0] FORCE_NONE = 2'h0;
  localparam logic [1:0] FORCE_DIFF1 = 2'h1;
  localparam logic [1:0] FORCE_DIFF0 = 2'h2;
  localparam logic [1:0] FORCE_SE0 = 2'h3;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CONN_TIME_NS = 2500;
  localparam int unsigned DISC_MIN_NS = 2000;
  // connect needs strictly more than the time
  localparam logic [CNT_W-1:0] CONN_CYC = CNT_W'(CONN_TIME_NS / CLK_PERIOD_NS + 1);
  // least disconnect time, rounded up
  localparam logic [CNT_W-1:0] DISC_CYC = CNT_W'((DISC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [NPORT-1:0] dp;
    logic [NPORT-1:0] dm;
  } hdp_line_t;

  typedef struct packed {
    logic [NPORT-1:0] dp;
    logic [NPORT-1:0] dm;
    logic [NPORT-1:0] oe;
    logic [NPORT-1:0] low_edge;
  } hdp_drive_t;

endpackage : hdp_pkg

// ===== rtl/hdp_qualifier.sv
// hdp_qualifier: timed connect/disconnect qualification for one port.
// assumes line inputs synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module hdp_qualifier (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic bus_reset_i,
  // line and state
  input wire logic dp_i,
  input wire logic dm_i,
  input wire logic connected_i,
  // events
  output logic connect_o,
  output logic low_speed_o,
  output logic disconnect_o
);

  logic [hdp_pkg::CNT_W-1:0] cnt_q;
  logic [hdp_pkg::CNT_W-1:0] cnt_d;
  logic se0;
  logic watch;
  logic hit;

  // ==========================================================
  // qualification counter
  always_comb
  begin
    se0 = ~dp_i & ~dm_i;
    // count the state that would change the recorded status
    watch = connected_i ? se0 : ~se0;
    hit = 1'b0;
    cnt_d = '0;
    if (watch)
    begin
      if (connected_i)
      begin
        hit = (cnt_q == hdp_pkg::DISC_CYC - 1'b1);
      end
      else
      begin
        hit = (cnt_q == hdp_pkg::CONN_CYC - 1'b1);
      end
      cnt_d = hit ? '0 : cnt_q + 1'b1;
    end
    if (bus_reset_i)
    begin
      cnt_d = '0;
      hit = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign connect_o = hit & ~connected_i;
  assign disconnect_o = hit & connected_i;
  assign low_speed_o = ~dp_i & dm_i;

endmodule : hdp_qualifier

`default_nettype wire

// ===== rtl/hdp_port_manager.sv
// hdp_port_manager: downstream port manager of a hub repeater, seven ports.
// assumes an APB master on the register side, synchronous line samples,
// and upstream repeater status and end-of-frame-2 strobe from the hub core.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - low-speed attach sets connect, raises interrupt
// - full-speed attach sets connect, clears speed
// - connect only after non-SE0 beyond 2.5 us
// - SE0 for 2.0 us clears connect, interrupt
// - connect bits per port, bit 7 zero
// - resets clear connect, hardware then updates
// - speed bit one means low speed
// - enable bit opens port both directions
// - enabled unsuspended port forwards unless babbling
// - no full-speed downstream traffic to low-speed ports
// - enable waits for end of current packet
// - interrupt on events while suspended, disabled ports
// - resets clear enables, bit 7 zero
// - babble at EOF2 clears port enable
// - two-bit field per port governs line drive
// - forced lines use the port speed edge rate
// - force fields survive USB bus reset
// - 00 none, 01 diff1, 10 diff0, 11 SE0
module hdp_port_manager (
  // clock and resets
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic bus_reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // downstream lines
  input wire hdp_pkg::hdp_line_t line_i,
  output hdp_pkg::hdp_drive_t drive_o,
  // upstream repeater side
  input wire logic us_active_i,
  input wire logic us_full_speed_i,
  input wire logic us_dp_i,
  input wire logic us_dm_i,
  input wire logic eof2_i,
  output logic [hdp_pkg::NPORT-1:0] us_forward_o,
  // status
  output logic [hdp_pkg::NPORT-1:0] port_enabled_o,
  output logic hub_irq_o
);

  localparam int unsigned N = hdp_pkg::NPORT;

  // ==========================================================
  // per-port qualifiers
  logic [N-1:0] conn_evt;
  logic [N-1:0] disc_evt;
  logic [N-1:0] ls_evt;
  logic [N-1:0] conn_q;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_port
      hdp_qualifier u_qual (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .bus_reset_i(bus_reset_i),
        .dp_i(line_i.dp[gi]),
        .dm_i(line_i.dm[gi]),
        .connected_i(conn_q[gi]),
        .connect_o(conn_evt[gi]),
        .low_speed_o(ls_evt[gi]),
        .disconnect_o(disc_evt[gi])
      );
    end
  endgenerate

  // ==========================================================
  // apb handshake, one wait state
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic wr;
  logic mapped;

  logic [N-1:0] speed_q;
  logic [N-1:0] en_q;
  logic [N-1:0] pend_q;
  logic [2*N-1:0] force_q;
  logic [N-1:0] susp_q;
  logic [1:0] hubctl_q;

  always_comb
  begin
    case (paddr_i)
      hdp_pkg::OFF_CONNECT,
      hdp_pkg::OFF_SPEED,
      hdp_pkg::OFF_ENABLE,
      hdp_pkg::OFF_FORCE,
      hdp_pkg::OFF_SUSPEND,
      hdp_pkg::OFF_HUBCTL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    pready_d = psel_i & penable_i & ~pready_q;
    pslverr_d = pready_d & ~mapped;
    prdata_d = '0;
    if (pready_d & ~pwrite_i)
    begin
      case (paddr_i)
        hdp_pkg::OFF_CONNECT: prdata_d = {25'h0000000, conn_q};
        hdp_pkg::OFF_SPEED: prdata_d = {25'h0000000, speed_q};
        hdp_pkg::OFF_ENABLE: prdata_d = {25'h0000000, en_q};
        hdp_pkg::OFF_FORCE: prdata_d = {18'h00000, force_q};
        hdp_pkg::OFF_SUSPEND: prdata_d = {25'h0000000, susp_q};
        hdp_pkg::OFF_HUBCTL: prdata_d = {30'h00000000, hubctl_q};
        default: prdata_d = '0;
      endcase
    end
    // writes land at the edge where pready is seen high
    wr = psel_i & penable_i & pready_q & pwrite_i;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign prdata_o = prdata_q;

  // ==========================================================
  // connect and speed status
  logic [N-1:0] conn_d;
  logic [N-1:0] speed_d;

  always_comb
  begin
    conn_d = conn_q;
    speed_d = speed_q;
    if (wr && paddr_i == hdp_pkg::OFF_CONNECT)
    begin
      conn_d = pwdata_i[N-1:0];
    end
    if (wr && paddr_i == hdp_pkg::OFF_SPEED)
    begin
      speed_d = pwdata_i[N-1:0];
    end
    // hardware events win over a same-cycle write
    conn_d = (conn_d | conn_evt) & ~disc_evt;
    speed_d = (speed_d & ~(conn_evt & ~ls_evt)) | (conn_evt & ls_evt);
    if (bus_reset_i)
    begin
      conn_d = hdp_pkg::PORTS_RST;
      speed_d = hdp_pkg::PORTS_RST;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      conn_q <= hdp_pkg::PORTS_RST;
      speed_q <= hdp_pkg::PORTS_RST;
    end
    else
    begin
      conn_q <= conn_d;
      speed_q <= speed_d;
    end
  end

  // ==========================================================
  // port enables, deferred enabling and babble
  logic [N-1:0] en_d;
  logic [N-1:0] pend_d;
  logic [N-1:0] line_idle;
  logic [N-1:0] babble;

  always_comb
  begin
    // idle is J: full speed dp high, low speed dm high
    line_idle = (line_i.dp & ~line_i.dm & ~speed_q) | (~line_i.dp & line_i.dm & speed_q);
    babble = '0;
    if (eof2_i)
    begin
      babble = en_q & (~line_idle | {N{us_active_i}});
    end
    en_d = en_q;
    pend_d = pend_q;
    if (wr && paddr_i == hdp_pkg::OFF_ENABLE)
    begin
      en_d = en_q & pwdata_i[N-1:0];
      pend_d = pwdata_i[N-1:0] & ~en_q;
    end
    if (!us_active_i)
    begin
      en_d = en_d | pend_d;
      pend_d = '0;
    end
    en_d = en_d & ~babble;
    pend_d = pend_d & ~babble;
    if (bus_reset_i)
    begin
      en_d = hdp_pkg::PORTS_RST;
      pend_d = hdp_pkg::PORTS_RST;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      en_q <= hdp_pkg::PORTS_RST;
      pend_q <= hdp_pkg::PORTS_RST;
    end
    else
    begin
      en_q <= en_d;
      pend_q <= pend_d;
    end
  end

  // ==========================================================
  // force fields, suspend bits and hub control
  logic [2*N-1:0] force_d;
  logic [N-1:0] susp_d;
  logic [1:0] hubctl_d;

  always_comb
  begin
    force_d = force_q;
    susp_d = susp_q;
    hubctl_d = hubctl_q;
    if (wr && paddr_i == hdp_pkg::OFF_FORCE)
    begin
      force_d = pwdata_i[2*N-1:0];
    end
    if (wr && paddr_i == hdp_pkg::OFF_SUSPEND)
    begin
      susp_d = pwdata_i[N-1:0];
    end
    if (wr && paddr_i == hdp_pkg::OFF_HUBCTL)
    begin
      hubctl_d = pwdata_i[1:0];
    end
    // force fields deliberately kept through bus reset
    if (bus_reset_i)
    begin
      susp_d = hdp_pkg::PORTS_RST;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      force_q <= hdp_pkg::FORCE_RST;
      susp_q <= hdp_pkg::PORTS_RST;
      hubctl_q <= hdp_pkg::HUBCTL_RST;
    end
    else
    begin
      force_q <= force_d;
      susp_q <= susp_d;
      hubctl_q <= hubctl_d;
    end
  end

  // ==========================================================
  // line drive and forwarding
  hdp_pkg::hdp_drive_t drive_d;
  hdp_pkg::hdp_drive_t drive_q;
  logic [N-1:0] fwd_d;
  logic [N-1:0] fwd_q;
  logic [N-1:0] active;
  logic irq_d;
  logic irq_q;

  always_comb
  begin
    active = en_q & ~susp_q & {N{~hubctl_q[hdp_pkg::HUBCTL_SUSP]}};
    fwd_d = active;
    drive_d.low_edge = speed_q;
    for (int i = 0; i < N; i++)
    begin
      drive_d.dp[i] = us_dp_i;
      drive_d.dm[i] = us_dm_i;
      drive_d.oe[i] = active[i] & us_active_i & ~(speed_q[i] & us_full_speed_i);
      case (force_q[2*i +: 2])
        hdp_pkg::FORCE_NONE:
        begin
          drive_d.oe[i] = drive_d.oe[i];
        end
        hdp_pkg::FORCE_DIFF1:
        begin
          drive_d.dp[i] = 1'b1;
          drive_d.dm[i] = 1'b0;
          drive_d.oe[i] = 1'b1;
        end
        hdp_pkg::FORCE_DIFF0:
        begin
          drive_d.dp[i] = 1'b0;
          drive_d.dm[i] = 1'b1;
          drive_d.oe[i] = 1'b1;
        end
        hdp_pkg::FORCE_SE0:
        begin
          drive_d.dp[i] = 1'b0;
          drive_d.dm[i] = 1'b0;
          drive_d.oe[i] = 1'b1;
        end
        default:
        begin
          drive_d.oe[i] = 1'b0;
        end
      endcase
    end
    // raised on any port change, enabled or not, suspended or not
    irq_d = hubctl_q[hdp_pkg::HUBCTL_IRQ_EN] & |(conn_evt | disc_evt);
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      drive_q <= '0;
      fwd_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      drive_q <= drive_d;
      fwd_q <= fwd_d;
      irq_q <= irq_d;
    end
  end

  assign drive_o = drive_q;
  assign us_forward_o = fwd_q;
  assign hub_irq_o = irq_q;
  assign port_enabled_o = en_q;

endmodule : hdp_port_manager

`default_nettype wire

// ===== verif/hdp_assertions.sv
// hdp_assertions: port-level checks of the port manager.
// assumes binding to hdp_port_manager, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module hdp_assertions (
  // clock and resets
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic bus_reset_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [31:0] prdata_o,
  // hub side
  input wire logic us_active_i,
  input wire logic eof2_i,
  input wire logic [6:0] port_enabled_o,
  input wire logic hub_irq_o
);
  // ====
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ready_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no ready after one wait state");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  idle_ready_a: assert property (!psel_i |=> !pready_o)
    else $error("ready without select");
  upper_zero_a: assert property (prdata_o[31:14] == '0)
    else $error("reserved read bits set");
  enable_rst_a: assert property (bus_reset_i |-> ##[1:2] port_enabled_o == '0)
    else $error("enables kept over bus reset");
  babble_clr_a: assert property (eof2_i && us_active_i |-> ##[1:2] port_enabled_o == '0)
    else $error("enable kept after babble");
  irq_rst_a: assert property ($past(bus_reset_i, 3) && bus_reset_i |-> !hub_irq_o)
    else $error("interrupt during bus reset");
  cover property (hub_irq_o);
  cover property (pslverr_o);
  cover property (eof2_i && us_active_i);
endmodule : hdp_assertions
`default_nettype wire

// ===== verif/hdp_dev_model.sv
// hdp_dev_model: attached devices on the seven downstream pairs.
// assumes pull-downs on every line, hub drive wins while its output enable is high.
`timescale 1ns/1ps
`default_nettype none
module hdp_dev_model (
  // control
  input wire logic [6:0] attach_i,
  input wire logic [6:0] low_i,
  // wire
  input wire hdp_pkg::hdp_drive_t drive_i,
  output hdp_pkg::hdp_line_t line_o
);
  // ====
  // pull-up on dp for full speed, dm for low speed
  assign line_o.dp = (drive_i.oe & drive_i.dp) | (~drive_i.oe & attach_i & ~low_i);
  assign line_o.dm = (drive_i.oe & drive_i.dm) | (~drive_i.oe & attach_i & low_i);
endmodule : hdp_dev_model
`default_nettype wire

// ===== verif/hdp_port_manager_tb_top.sv
// hdp_port_manager_tb_top: random and directed bench of the port manager.
// assumes the device model on the lines and an APB master here.
`timescale 1ns/1ps
`default_nettype none
module hdp_port_manager_tb_top;
  logic clk_i = 0, reset_i = 1, brst = 0, psel = 0, pen = 0, pwr = 0, act = 0, fs = 0, eof2 = 0;
  logic rdy, err, e_seen, irq;
  logic [7:0] pa = 8'h00, rnd = 8'h06;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [6:0] att = 7'h00, low = 7'h00, fwd, pen_o, a_m, l_m;
  hdp_pkg::hdp_line_t line;
  hdp_pkg::hdp_drive_t drv;
  int n_fail = 0, n_checks = 0, n_irq = 0, c;

  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (irq === 1'b1) n_irq <= n_irq + 1;

  hdp_port_manager dut_u (.clk_i(clk_i), .reset_i(reset_i), .bus_reset_i(brst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .line_i(line),
    .drive_o(drv), .us_active_i(act), .us_full_speed_i(fs), .us_dp_i(1'b1), .us_dm_i(1'b0), .eof2_i(eof2),
    .us_forward_o(fwd), .port_enabled_o(pen_o), .hub_irq_o(irq));
  hdp_dev_model dev_u (.attach_i(att), .low_i(low), .drive_i(drv), .line_o(line));

  // ====
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic hang;
    n_fail++;
    close_out;
  endtask : hang

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_i);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (rdy !== 1'b1 && i < 20);
    rd = prd;
    e_seen = err;
    psel <= 0;
    pen <= 0;
    if (i >= 20) hang;
  endtask : apb

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdchk

  task automatic wirq(output int k);
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (irq !== 1'b1 && k < 60);
    if (k >= 60) hang;
  endtask : wirq

  task automatic brst_t;
    brst <= 1;
    repeat (4) @(posedge clk_i);
    brst <= 0;
  endtask : brst_t

  // ====
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_i <= 0;
    rdchk("connect", hdp_pkg::OFF_CONNECT, 32'h0);
    rdchk("speed", hdp_pkg::OFF_SPEED, 32'h0);
    rdchk("enable", hdp_pkg::OFF_ENABLE, 32'h0);
    rdchk("force", hdp_pkg::OFF_FORCE, 32'h0);
    rdchk("unmapped", 8'h18, 32'h0);
    chk("slverr", e_seen, 1);
    apb(1, hdp_pkg::OFF_HUBCTL, 32'h1);
    att <= 7'h7f;
    repeat (20) @(posedge clk_i);
    att <= 7'h00;
    repeat (30) @(posedge clk_i);
    chk("glitch irq", n_irq, 0);
    rnd = lfsr(rnd);
    a_m = rnd[6:0] | 7'h01;
    rnd = lfsr(rnd);
    l_m = rnd[6:0] & a_m;
    att <= a_m;
    low <= l_m;
    wirq(c);
    chk("connect time", c > 25 && c < 32, 1);
    rdchk("connect", hdp_pkg::OFF_CONNECT, a_m);
    rdchk("speed", hdp_pkg::OFF_SPEED, l_m);
    act <= 1;
    apb(1, hdp_pkg::OFF_ENABLE, 32'hff);
    repeat (3) @(posedge clk_i);
    chk("pending", pen_o, 0);
    act <= 0;
    repeat (3) @(posedge clk_i);
    chk("enabled", pen_o, 32'h7f);
    rdchk("enable", hdp_pkg::OFF_ENABLE, 32'h7f);
    act <= 1;
    fs <= 1;
    repeat (3) @(posedge clk_i);
    chk("fs oe", drv.oe, {25'h0, ~l_m});
    chk("forward", fwd, 32'h7f);
    fs <= 0;
    repeat (3) @(posedge clk_i);
    chk("ls oe", drv.oe, 32'h7f);
    eof2 <= 1;
    @(posedge clk_i);
    eof2 <= 0;
    repeat (3) @(posedge clk_i);
    chk("babble", pen_o, 0);
    act <= 0;
    apb(1, hdp_pkg::OFF_ENABLE, 32'h7f);
    apb(1, hdp_pkg::OFF_SUSPEND, 32'h05);
    repeat (2) @(posedge clk_i);
    chk("suspended fwd", fwd, 32'h7a);
    brst_t;
    rdchk("enable", hdp_pkg::OFF_ENABLE, 32'h0);
    rdchk("speed", hdp_pkg::OFF_SPEED, 32'h0);
    rdchk("connect", hdp_pkg::OFF_CONNECT, 32'h0);
    rnd = lfsr(rnd);
    pwd <= {18'h0, rnd[5:0], lfsr(rnd)};
    apb(1, hdp_pkg::OFF_FORCE, {18'h0, rnd[5:0], lfsr(rnd)});
    brst_t;
    rdchk("force", hdp_pkg::OFF_FORCE, {18'h0, rnd[5:0], lfsr(rnd)});
    apb(1, hdp_pkg::OFF_FORCE, 32'h0);
    wirq(c);
    rdchk("reconnect", hdp_pkg::OFF_CONNECT, a_m);
    rdchk("speed", hdp_pkg::OFF_SPEED, l_m);
    apb(1, hdp_pkg::OFF_SPEED, 32'h55);
    for (int k = 0; k < 4; k++)
    begin
      apb(1, hdp_pkg::OFF_FORCE, {18'h0, {7{k[1:0]}}});
      repeat (2) @(posedge clk_i);
      chk("force oe", drv.oe, (k != 0) ? 32'h7f : 32'h0);
      if (k != 0)
      begin
        chk("force dp", drv.dp, {7{k == 1}});
        chk("force dm", drv.dm, {7{k == 2}});
        chk("edge rate", drv.low_edge, 32'h55);
      end
    end
    apb(1, hdp_pkg::OFF_FORCE, 32'h0);
    apb(1, hdp_pkg::OFF_HUBCTL, 32'h3);
    att <= 7'h00;
    wirq(c);
    chk("disc time", c >= 20 && c <= 27, 1);
    rdchk("connect", hdp_pkg::OFF_CONNECT, 32'h0);
    close_out;
  end
endmodule : hdp_port_manager_tb_top

bind hdp_port_manager hdp_assertions chk_u (.clk_i(clk_i), .reset_i(reset_i), .bus_reset_i(bus_reset_i),
  .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
  .us_active_i(us_active_i), .eof2_i(eof2_i), .port_enabled_o(port_enabled_o), .hub_irq_o(hub_irq_o));
`default_nettype wire
